// file: rtl/sepr_top.sv
// Purpose: slave core of a two-wire 16K byte eeprom with protection byte
// Assumes: pins sampled on clk; write datapath limited to fifo-buffered bytes
// Notes:   nonvolatile protection bits are held in flops and reset with the core; the array bytes are not reset
`timescale 1ns/100ps
`default_nettype none

module sepr_fifo #(
   parameter int W     = 22,
   parameter int DEPTH = 16
) (
   input  wire logic         clk,       // core clock
   input  wire logic         rst_n,     // synchronous reset, low
   input  wire logic         flush,     // drop all entries
   input  wire logic         in_valid,  // write request
   output logic              in_ready,  // room available
   input  wire logic [W-1:0] in_data,   // write word
   output logic              out_valid, // word available
   input  wire logic         out_ready, // consumer takes word
   output logic [W-1:0]      out_data   // head word
);
   localparam int PW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two");
   end
   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0]   cnt;
   } sepr_fst_t;
   sepr_fst_t q, d;
   logic [W-1:0] mem [DEPTH];
   logic push, pop;

   always_comb begin
      in_ready  = (q.cnt != (PW+1)'(DEPTH));
      out_valid = (q.cnt != '0);
      out_data  = mem[q.rp];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      d = q;
      if (push) begin
         d.wp = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
      if (flush) begin
         d = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[q.wp] <= in_data;
      end
   end
endmodule

module sepr_top
   import sepr_pkg::*;
#(
   parameter int WC_CYCLES = (WC_TIME_US * CLK_MHZ)
) (
   input  wire logic       clk,      // 40 MHz core clock
   input  wire logic       rst_n,    // synchronous reset, low
   input  wire logic       scl_i,    // serial clock pin
   input  wire logic       sda_i,    // serial data pin level
   output logic            sda_o,    // serial data drive value
   output logic            sda_oe,   // high while pulling data low
   input  wire logic [2:0] dev_sel,  // device select straps
   input  wire logic       wp_i,     // write protect pin
   output logic            busy_o    // write cycle running
);
   if (WC_CYCLES < 1 || WC_CYCLES > (1 << 20)) begin : g_chk
      $error("write cycle count out of range");
   end

   typedef struct packed {
      logic [2:0]  s1, s2, s3, f, fp;
      sepr_st_t    st;
      logic [3:0]  bitcnt;
      logic [7:0]  sh;
      logic        in_ack;
      logic        rw;
      logic        mack;
      logic [7:0]  wa_hi;
      logic [15:0] addr;
      logic        write_enable_latch, register_write_latch, arm;
      logic [1:0]  bl;
      logic        regseen;
      logic [7:0]  regdat;
      logic        anydata, blocked;
      logic        busy, nv_reg;
      logic [2:0]  nv_bits;
      logic [19:0] timer;
      logic        oe, drv;
   } sepr_state_t;

   sepr_state_t q, d;
   logic [7:0] arr [1 << ADDR_W];

   sepr_wr_t wr_in, wr_out;
   logic     f_flush, f_push, f_ready, f_valid, f_pop;
   logic     scl, sda, wp, rise, fall, start_c, stop_c;
   logic     hw_lock, ack_now, inc_rd, wr_byte;
   logic [7:0] prot_byte;

   function automatic logic locked(input logic [ADDR_W-1:0] a,
                                   input logic [1:0] bl);
      case (bl)
         LK_NONE:    locked = 1'b0;
         LK_QUARTER: locked = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
         LK_HALF:    locked = a[ADDR_W-1];
         default:    locked = 1'b1;
      endcase
   endfunction

   function automatic logic [15:0] rd_next(input logic [15:0] a);
      rd_next = {2'h0, a[ADDR_W-1:0] + 14'h0001};
   endfunction

   sepr_fifo #(.W($bits(sepr_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (f_flush),
      .in_valid  (f_push),
      .in_ready  (f_ready),
      .in_data   (wr_in),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (wr_out)
   );

   always_comb begin
      d = q;
      scl = q.f[0];
      sda = q.f[1];
      wp  = q.f[2];
      rise    = q.f[0] && !q.fp[0];
      fall    = !q.f[0] && q.fp[0];
      start_c = q.f[0] && q.fp[0] && q.fp[1] && !q.f[1];
      stop_c  = q.f[0] && q.fp[0] && !q.fp[1] && q.f[1];
      hw_lock = wp && q.arm;
      prot_byte = '0;
      prot_byte[BIT_ARM]  = q.arm;
      prot_byte[BIT_LKH]  = q.bl[1];
      prot_byte[BIT_LKL]  = q.bl[0];
      prot_byte[BIT_REGISTER_WRITE_LATCH] = q.register_write_latch;
      prot_byte[BIT_WEL]  = q.write_enable_latch;
      ack_now = 1'b0;
      inc_rd  = 1'b0;
      wr_byte = 1'b0;
      f_flush = 1'b0;
      f_push  = 1'b0;
      f_pop   = 1'b0;
      wr_in   = '{addr: q.addr[ADDR_W-1:0], data: q.sh};

      d.s1 = {wp_i, sda_i, scl_i};
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < 3; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.f[i] = q.s3[i];
         end
      end
      d.fp = q.f;

      if (q.busy) begin
         f_pop = f_valid;
         if (q.timer != 20'(WC_CYCLES - 1)) begin
            d.timer = q.timer + 20'h1;
         end else if (!f_valid) begin
            d.busy = 1'b0;
            d.register_write_latch = 1'b0;
            if (q.nv_reg) begin
               d.arm = q.nv_bits[2];
               d.bl  = q.nv_bits[1:0];
            end
         end
      end

      if (start_c) begin
         // an unfinished write or register step is dropped here
         f_flush   = q.anydata;
         d.st      = S_ADDR;
         d.bitcnt  = '0;
         d.in_ack  = 1'b0;
         d.oe      = 1'b0;
         d.regseen = 1'b0;
         d.anydata = 1'b0;
         d.blocked = 1'b0;
      end else if (stop_c) begin
         d.st     = S_IDLE;
         d.oe     = 1'b0;
         d.in_ack = 1'b0;
         if (q.regseen) begin
            if ((q.regdat & RSV_MASK) != 8'h00) begin
               d.write_enable_latch = q.write_enable_latch;
            end else if (!q.register_write_latch) begin
               if (q.regdat == PAT_WEL_SET) begin
                  d.write_enable_latch = 1'b1;
               end else if (q.regdat == PAT_WEL_CLR) begin
                  d.write_enable_latch = 1'b0;
               end else if (q.regdat == PAT_REGISTER_WRITE_LATCH_SET && q.write_enable_latch) begin
                  d.register_write_latch = 1'b1;
               end
               // anything touching lock or arm is refused here
            end else if (q.regdat[BIT_REGISTER_WRITE_LATCH]) begin
               d.register_write_latch = q.register_write_latch;
            end else if (q.regdat[BIT_WEL] && !hw_lock) begin
               d.busy    = 1'b1;
               d.timer   = '0;
               d.nv_reg  = 1'b1;
               d.nv_bits = {q.regdat[BIT_ARM], q.regdat[BIT_LKH],
                            q.regdat[BIT_LKL]};
            end
         end else if (q.anydata) begin
            if (q.blocked) begin
               f_flush = 1'b1;
            end else begin
               d.busy   = 1'b1;
               d.timer  = '0;
               d.nv_reg = 1'b0;
            end
         end
         d.regseen = 1'b0;
         d.anydata = 1'b0;
         d.blocked = 1'b0;
      end else begin
         case (q.st)
            S_ADDR, S_WA1, S_WA0, S_WDAT: begin
               if (rise && !q.in_ack) begin
                  d.sh     = {q.sh[6:0], sda};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (fall && q.in_ack) begin
                  d.oe     = 1'b0;
                  d.in_ack = 1'b0;
                  d.bitcnt = '0;
                  if (!q.oe) begin
                     d.st = S_IGN;
                  end else if (q.st == S_ADDR) begin
                     d.st = q.rw ? S_RDAT : S_WA1;
                  end else if (q.st == S_WA1) begin
                     d.st = S_WA0;
                  end else begin
                     d.st = S_WDAT;
                  end
                  if (q.oe && q.st == S_ADDR && q.rw) begin
                     d.sh  = (q.addr == REG_ADDR) ? prot_byte
                             : arr[q.addr[ADDR_W-1:0]];
                     d.oe  = 1'b0;
                     d.drv = 1'b1;
                  end
               end else if (fall && q.bitcnt == BITS_BYTE) begin
                  d.in_ack = 1'b1;
                  case (q.st)
                     S_ADDR: begin
                        ack_now = (q.sh[7:4] == DEV_TYPE) &&
                                  (q.sh[3:1] == dev_sel) && !q.busy;
                        d.rw = q.sh[0];
                     end
                     S_WA1: begin
                        ack_now = 1'b1;
                        d.wa_hi = q.sh;
                     end
                     S_WA0: begin
                        ack_now = 1'b1;
                        d.addr  = {q.wa_hi, q.sh};
                     end
                     default: begin
                        if (q.addr == REG_ADDR) begin
                           ack_now   = !q.regseen;
                           d.regseen = 1'b1;
                           // only the first byte counts; later ones are nacked
                           if (!q.regseen) begin
                              d.regdat = q.sh;
                           end
                        end else begin
                           ack_now = q.write_enable_latch && f_ready;
                           if (ack_now) begin
                              wr_byte   = 1'b1;
                              f_push    = 1'b1;
                              d.anydata = 1'b1;
                              if (locked(q.addr[ADDR_W-1:0], q.bl)) begin
                                 d.blocked = 1'b1;
                              end
                              d.addr = {2'h0, q.addr[ADDR_W-1:PAGE_W],
                                        q.addr[PAGE_W-1:0] + 5'h01};
                           end
                        end
                     end
                  endcase
                  d.oe = ack_now;
               end
            end
            S_RDAT: begin
               if (q.drv && q.bitcnt == '0) begin
                  d.oe  = !q.sh[7];
                  d.drv = 1'b0;
               end else if (rise) begin
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (fall) begin
                  if (q.bitcnt == BITS_BYTE) begin
                     d.oe     = 1'b0;
                     d.bitcnt = '0;
                     if (q.addr == REG_ADDR) begin
                        d.addr = '0;
                        d.st   = S_IDLE;
                     end else begin
                        inc_rd = 1'b1;
                        d.addr = rd_next(q.addr);
                        d.st   = S_RACK;
                     end
                  end else begin
                     d.sh = {q.sh[6:0], 1'b0};
                     d.oe = !q.sh[6];
                  end
               end
            end
            S_RACK: begin
               if (rise) begin
                  d.mack = !sda;
               end else if (fall && q.fp[0]) begin
                  d.st = S_IGN;
               end else if (fall) begin
                  d.st = S_IGN;
               end
               if (fall && q.mack) begin
                  d.st  = S_RDAT;
                  d.sh  = arr[q.addr[ADDR_W-1:0]];
                  d.drv = 1'b1;
               end
               if (rise == 1'b0 && fall) begin
                  d.mack = 1'b0;
               end
            end
            default: begin
               d.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
         q.s1 <= 3'h3;
         q.s2 <= 3'h3;
         q.s3 <= 3'h3;
         q.f  <= 3'h3;
         q.fp <= 3'h3;
         q.st <= S_IDLE;
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge clk) begin
      if (f_pop) begin
         arr[wr_out.addr] <= wr_out.data;
      end
   end

   assign sda_o  = q.drv & 1'b0;
   assign sda_oe = q.oe;
   assign busy_o = q.busy;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   busy_no_ack_a: assert property (q.busy && q.st == S_ADDR |-> !d.oe)
      else $error("address acknowledged during write cycle");
   read_wrap_a: assert property (inc_rd && q.addr == {2'h0, ARR_TOP}
      |=> q.addr == 16'h0000)
      else $error("read counter did not wrap to zero");
   page_wrap_a: assert property (wr_byte && q.addr[PAGE_W-1:0] == 5'h1F
      |=> q.addr[PAGE_W-1:0] == 5'h00
          && q.addr[ADDR_W-1:PAGE_W] == $past(q.addr[ADDR_W-1:PAGE_W]))
      else $error("page write counter left its page");
   latch_pu_a: assert property ($rose(rst_n) |-> !q.write_enable_latch && !q.register_write_latch)
      else $error("volatile latches not clear after reset");
   reg_one_a: assert property (q.st == S_WDAT && q.regseen
      && fall && q.bitcnt == BITS_BYTE && !q.in_ack |=> !q.oe)
      else $error("second protection byte acknowledged");
   wel_gate_a: assert property (wr_byte |-> q.write_enable_latch)
      else $error("array byte accepted with enable latch clear");
   register_write_latch_clr_a: assert property ($fell(q.busy) |-> !q.register_write_latch)
      else $error("register latch survived a write cycle");
   hw_block_a: assert property ($rose(q.busy) && q.nv_reg
      |-> !$past(hw_lock))
      else $error("protected register write started");
   reg_read_a: assert property (q.st == S_RDAT && fall
      && q.bitcnt == BITS_BYTE && q.addr == REG_ADDR
      |=> q.addr == 16'h0000 && q.st == S_IDLE)
      else $error("counter not zero after register read");
endmodule

`default_nettype wire

// file: rtl/sepr_pkg.sv
// Purpose: constants and types of the two-wire eeprom slave core
// Assumes: 40 MHz clock, array of 16K bytes, protection byte at the top address
// Notes:   Contract
package sepr_pkg;
   localparam int          CLK_MHZ      = 40;
   localparam int          WC_TIME_US   = 5000;
   localparam int          ADDR_W       = 14;
   localparam int          PAGE_W       = 5;
   localparam logic [3:0]  DEV_TYPE     = 4'hA;
   localparam logic [15:0] REG_ADDR     = 16'hFFFF;
   localparam logic [13:0] ARR_TOP      = 14'h3FFF;
   localparam logic [7:0]  RSV_MASK     = 8'h61;
   localparam logic [7:0]  PAT_WEL_SET  = 8'h02;
   localparam logic [7:0]  PAT_WEL_CLR  = 8'h00;
   localparam logic [7:0]  PAT_REGISTER_WRITE_LATCH_SET = 8'h06;
   localparam int          BIT_ARM      = 7;
   localparam int          BIT_LKH      = 4;
   localparam int          BIT_LKL      = 3;
   localparam int          BIT_REGISTER_WRITE_LATCH     = 2;
   localparam int          BIT_WEL      = 1;
   localparam logic [3:0]  BITS_BYTE    = 4'h8;
   localparam logic [1:0]  LK_NONE      = 2'h0;
   localparam logic [1:0]  LK_QUARTER   = 2'h1;
   localparam logic [1:0]  LK_HALF      = 2'h2;
   localparam int          FIFO_DEPTH   = 16;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_WA1, S_WA0, S_WDAT, S_RDAT, S_RACK, S_IGN
   } sepr_st_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } sepr_wr_t;
endpackage

// file: bench/sepr_master.sv
// Purpose: two-wire bus master model that drives the serial clock
// Assumes: data line has a pull-up; a released line reads high
// Notes:   each clock half lasts about ten core clocks
`timescale 1ns/100ps
`default_nettype none

module sepr_master (
   input  wire logic clk,    // core clock
   input  wire logic sda,    // resolved data line
   output logic      scl,    // serial clock, high when idle
   output logic      sda_lo  // master pulls data low
);
   initial begin
      scl    = 1'b1;
      sda_lo = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // start or repeated start, data falls while the clock is high
   task automatic start();
      sda_lo = 1'b0;
      tick(8);
      scl = 1'b1;
      tick(10);
      sda_lo = 1'b1;
      tick(10);
      scl = 1'b0;
      tick(3);
   endtask

   task automatic stop();
      sda_lo = 1'b1;
      tick(8);
      scl = 1'b1;
      tick(10);
      sda_lo = 1'b0;
      tick(20);
   endtask

   // data only moves while the clock is low
   task automatic bitx(input logic b, output logic r);
      sda_lo = !b;
      tick(8);
      scl = 1'b1;
      tick(10);
      r   = sda;
      scl = 1'b0;
      tick(3);
   endtask

   // eight bits msb first, then the ninth clock driven with nine
   task automatic xfer(input logic [7:0] d, input logic nine,
                       output logic [7:0] r, output logic a);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r[i]);
      bitx(nine, s);
      a = !s;
   endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench for the eeprom slave core
// Assumes: short write cycle parameter, straps 101, pull-up on data
// Notes:   each test is one task that judges its own results
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import sepr_pkg::*;
   localparam int WC = 400;
   logic     clk, rst_n, wp_i, scl, m_lo, sda_o, sda_oe, busy_o;
   wire      sda;
   int       bad_count, checks, cyc;

   assign sda = !(m_lo | (sda_oe & !sda_o));

   sepr_top #(.WC_CYCLES(WC)) dut (
      .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .dev_sel(3'h5), .wp_i(wp_i),
      .busy_o(busy_o));
   sepr_master m (.clk(clk), .sda(sda), .scl(scl), .sda_lo(m_lo));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d bad %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d,
                     input int n, output logic ak);
      logic [7:0] r;
      m.start();
      m.xfer(8'hAA, 1'b1, r, ak);
      m.xfer(a[15:8], 1'b1, r, ak);
      m.xfer(a[7:0], 1'b1, r, ak);
      for (int i = 0; i < n; i++)
         m.xfer(d + 8'(i), 1'b1, r, ak);
      m.stop();
   endtask

   task automatic rd(input logic rnd, input logic [15:0] a,
                     input logic two, output logic [7:0] b0,
                     output logic [7:0] b1);
      logic ak;
      m.start();
      if (rnd) begin
         m.xfer(8'hAA, 1'b1, b0, ak);
         m.xfer(a[15:8], 1'b1, b0, ak);
         m.xfer(a[7:0], 1'b1, b0, ak);
         m.start();
      end
      m.xfer(8'hAB, 1'b1, b0, ak);
      chk(8'(ak), 8'h01);
      m.xfer(8'hFF, !two, b0, ak);
      if (two)
         m.xfer(8'hFF, 1'b1, b1, ak);
      m.stop();
   endtask

   // checks whether a write cycle started, then polls until it is over
   task automatic after(input logic nvw);
      logic [7:0] r;
      logic ak;
      int n;
      chk(8'(busy_o), 8'(nvw));
      n  = 0;
      ak = 1'b0;
      while (nvw && !ak && n < 40) begin
         m.start();
         m.xfer(8'hAA, 1'b1, r, ak);
         m.stop();
         n++;
      end
      if (nvw)
         chk(8'(n > 1), 8'h01);
      chk(8'(busy_o), 8'h00);
   endtask

   task automatic t_latch();
      logic [7:0] q, x;
      logic ak;
      rd(1'b1, 16'hFFFF, 1'b0, q, x);
      chk(q, 8'h00);
      wr(16'h0010, 8'h11, 1, ak);
      chk(8'(ak), 8'h00);
      after(1'b0);
      wr(16'hFFFF, 8'h02, 1, ak);
      chk(8'(ak), 8'h01);
      after(1'b0);
      rd(1'b1, 16'hFFFF, 1'b0, q, x);
      chk(q, 8'h02);
      $display("test latch done");
   endtask

   task automatic t_page();
      logic [7:0] q, x;
      logic ak;
      wr(16'h001F, 8'h5A, 2, ak);
      chk(8'(ak), 8'h01);
      after(1'b1);
      wr(16'h001F, 8'h77, 1, ak);
      after(1'b1);
      rd(1'b0, 16'h0000, 1'b0, q, x);
      chk(q, 8'h5B);
      rd(1'b1, 16'h3FFF, 1'b1, q, x);
      chk(x, 8'h5B);
      wr(16'h001F, 8'h00, 0, ak);
      after(1'b0);
      rd(1'b0, 16'h0000, 1'b0, q, x);
      chk(q, 8'h77);
      rd(1'b1, 16'hFFFF, 1'b0, q, x);
      rd(1'b0, 16'h0000, 1'b0, q, x);
      chk(q, 8'h5B);
      $display("test page done");
   endtask

   task automatic t_lock();
      logic [7:0] q, x;
      logic ak;
      wr(16'hFFFF, 8'h06, 1, ak);
      after(1'b0);
      wr(16'hFFFF, 8'h1A, 1, ak);
      after(1'b1);
      rd(1'b1, 16'hFFFF, 1'b0, q, x);
      chk(q, 8'h1A);
      wr(16'h0100, 8'h33, 1, ak);
      chk(8'(ak), 8'h01);
      after(1'b0);
      wr(16'hFFFF, 8'h02, 2, ak);
      chk(8'(ak), 8'h00);
      wr(16'hFFFF, 8'h12, 1, ak);
      after(1'b0);
      wr(16'hFFFF, 8'h06, 1, ak);
      wr(16'hFFFF, 8'h42, 1, ak);
      after(1'b0);
      rd(1'b1, 16'hFFFF, 1'b0, q, x);
      chk(q, 8'h1E);
      wr(16'hFFFF, 8'h0A, 1, ak);
      after(1'b1);
      wr(16'h3000, 8'h21, 1, ak);
      after(1'b0);
      wr(16'h2FFF, 8'h22, 1, ak);
      after(1'b1);
      $display("test lock done");
   endtask

   task automatic t_hwp();
      logic [7:0] q, x;
      logic ak;
      wr(16'hFFFF, 8'h06, 1, ak);
      wr(16'hFFFF, 8'h82, 1, ak);
      after(1'b1);
      wp_i = 1'b1;
      wr(16'hFFFF, 8'h06, 1, ak);
      after(1'b0);
      wr(16'hFFFF, 8'h9A, 1, ak);
      after(1'b0);
      rd(1'b1, 16'hFFFF, 1'b0, q, x);
      chk(q & 8'h98, 8'h80);
      wr(16'h0000, 8'h44, 1, ak);
      after(1'b1);
      wp_i = 1'b0;
      $display("test protect done");
   endtask

   initial begin
      rst_n = 1'b0;
      wp_i  = 1'b0;
      repeat (5) @(posedge clk);
      #2 rst_n = 1'b1;
      repeat (8) @(posedge clk);
      t_latch();
      t_page();
      t_lock();
      t_hwp();
      report_and_stop();
   end
endmodule
`default_nettype wire
